// ---- cb_consts.svh ----
// constants for the cell balancing control block
`ifndef CB_CONSTS_SVH
`define CB_CONSTS_SVH
// Overview of operation
// - non-disabled mode write restarts timer, launches mode
// - state field reports disabled/active/done/halted
// - mode codes 000..011: off, discharge, manual
// - mode codes 1xx: automatic individual or group
// - filter init, then skip 16 scans of checks
// - hold 01 keeps shutdown high during automated operation
// - hold 10 adds max(5 min, expiry/16) in automated modes
// - hold 11 keeps shutdown high until removed, automated modes only
// - duty n switches on n+1 sixteenths of each even/odd period
// - done enable gates done into summary alert
// - thermal exit enable halts on temperature alert
// - measurement enable selects measurements and checks
// - control register reads zero after reset
// - read-only status register shows progress
// - status persists until disable or new launch
// - status mirrors state in bits 15:14

// register indices, byte address is four times the index
`define CB_IDX_CONTROL     8'h80
`define CB_IDX_STATUS      8'h81
`define CB_IDX_EXPIRY      8'h83
`define CB_IDX_ALERTS      8'h84
`define CB_ADDR_CONTROL    {`CB_IDX_CONTROL, 2'b00}
`define CB_ADDR_STATUS     {`CB_IDX_STATUS, 2'b00}
`define CB_ADDR_EXPIRY     {`CB_IDX_EXPIRY, 2'b00}
`define CB_ADDR_ALERTS     {`CB_IDX_ALERTS, 2'b00}

// field positions of the control word
`define CB_STATE_LSB       14
`define CB_MODE_LSB        11
`define CB_CTRL_MSB        13

// mode codes
`define CB_MODE_DISABLED   3'b000
`define CB_MODE_DISCHARGE  3'b001
`define CB_MODE_MAN_SEC    3'b010
`define CB_MODE_MAN_MIN    3'b011

// reset values
`define CB_CTRL_RESET      14'h0000
`define CB_EXP_RESET       10'h3ff
`define CB_EXP_INFINITE    10'h3ff

// timing
`define CB_CLK_PERIOD_NS   10
`define CB_SECOND_NS       1000000000
`define CB_EOP_NS          100000
`define CB_NOL_NS          1000
`define CB_SEC_PER_MIN     60
`define CB_SEC_PER_HOUR    3600
`define CB_HOLD_MIN_SEC    300
`define CB_IIR_SETTLE      5'd16
`define CB_DUTY_SLICES     16
`endif

// ---- cb_pkg.sv ----
// types shared by the cell balancing control block
package cb_pkg;
  typedef struct packed {
    logic [2:0] mode;
    logic       iir_init;
    logic [1:0] hold;
    logic [3:0] duty;
    logic       done_en;
    logic       temp_en;
    logic [1:0] meas_en;
  } ctrl_t;

  typedef struct packed {
    logic cal;
    logic timeout;
    logic thermal;
    logic done;
  } alerts_t;

  typedef enum logic [1:0] {
    BAL_DISABLED = 2'b00,
    BAL_ACTIVE   = 2'b01,
    BAL_DONE     = 2'b10,
    BAL_HALTED   = 2'b11
  } bal_state_t;

  typedef enum logic [1:0] {
    UNIT_NONE = 2'b00,
    UNIT_SEC  = 2'b01,
    UNIT_MIN  = 2'b10,
    UNIT_HOUR = 2'b11
  } unit_t;

  typedef enum logic [2:0] {
    RUN_IDLE = 3'b001,
    RUN_BUSY = 3'b010,
    RUN_END  = 3'b100
  } run_state_t;
endpackage

// ---- cb_sync3.sv ----
// three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
module cb_sync3 #(
  parameter int W = 4
) (
  input  wire logic         clk,    // system clock
  input  wire logic         rst_n,  // synchronised reset, active low
  input  wire logic [W-1:0] d,      // asynchronous inputs
  output logic      [W-1:0] q       // filtered, synchronous copy
);
  logic [W-1:0] s1_q, s2_q, s3_q, q_d;

  // a change counts only once stages two and three agree
  always_comb begin
    q_d = q;
    for (int i = 0; i < W; i++) begin
      if (s2_q[i] == s3_q[i]) begin
        q_d[i] = s3_q[i];
      end
    end
  end

  // stage one feeds stage two only
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      q    <= '0;
    end else begin
      s1_q <= d;
      s2_q <= s1_q;
      s3_q <= s2_q;
      q    <= q_d;
    end
  end
endmodule

// ---- cb_tick.sv ----
// restartable divider giving a one-cycle tick every DIV cycles
`timescale 1ns/1ps
module cb_tick #(
  parameter int DIV = 100
) (
  input  wire logic clk,    // system clock
  input  wire logic rst_n,  // synchronised reset, active low
  input  wire logic clr,    // restart the count
  output logic      tick    // one-cycle pulse
);
  localparam int CW = $clog2(DIV) + 1;
  logic [CW-1:0] cnt_q, cnt_d;
  logic          tick_d;

  // clearing realigns the phase so the first tick is a full period away
  always_comb begin
    tick_d = 1'b0;
    cnt_d  = cnt_q + CW'(1);
    if (clr) begin
      cnt_d = '0;
    end else if (cnt_q == CW'(DIV - 1)) begin
      cnt_d  = '0;
      tick_d = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= '0;
      tick  <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      tick  <= tick_d;
    end
  end
endmodule

// ---- cell_balance_control.sv ----
// cell balancing control registers, mode launcher and switch timing
//
// Register access over Wishbone is this design's own decision.
`timescale 1ns/1ps
`include "cb_consts.svh"
module cell_balance_control
  import cb_pkg::*;
#(
  parameter int SEC_CYC = `CB_SECOND_NS / `CB_CLK_PERIOD_NS,
  parameter int EOP_CYC = `CB_EOP_NS / `CB_CLK_PERIOD_NS
) (
  input  wire logic        CLK,            // 100 MHz system clock
  input  wire logic        ARST_N,         // asynchronous reset, low
  input  wire logic        WB_CYC_I,       // wishbone cycle
  input  wire logic        WB_STB_I,       // wishbone strobe
  input  wire logic        WB_WE_I,        // wishbone write enable
  input  wire logic [9:0]  WB_ADR_I,       // wishbone byte address
  input  wire logic [3:0]  WB_SEL_I,       // wishbone byte selects
  input  wire logic [31:0] WB_DAT_I,       // wishbone write data
  output logic      [31:0] WB_DAT_O,       // wishbone read data
  output logic             WB_ACK_O,       // wishbone acknowledge
  input  wire logic        TEMP_ALERT,     // temperature alert pin
  input  wire logic        UV_REACHED,     // all cells at threshold
  input  wire logic        CAL_FAULT,      // calibration fault pin
  input  wire logic        MEAS_TIMEOUT,   // measurement timeout pin
  input  wire logic        SCAN_DONE,      // scan finished, same clock
  output logic             SHUTDOWN_PIN,   // shutdown hold output
  output logic             EVEN_SWITCH_EN, // even balancing switches
  output logic             ODD_SWITCH_EN,  // odd balancing switches
  output logic             MEAS_ENABLE,    // embedded measurements on
  output logic             UV_CHECK_EN,    // threshold checks on
  output logic             FILTER_INIT,    // filter init request
  output logic             SUMMARY_ALERT   // summary balancing alert
);
  localparam int SLICE_CYC = EOP_CYC / `CB_DUTY_SLICES;
  localparam int NOL_CYC =
    (`CB_NOL_NS + `CB_CLK_PERIOD_NS - 1) / `CB_CLK_PERIOD_NS;

  logic        rst_s1_q, rst_s2_q, rst_n;
  logic [3:0]  pins_s;
  logic        temp_s, uv_s, cal_s, tmo_s;
  logic        sec_tick, slice_tick;

  ctrl_t       ctrl_q, ctrl_d;
  bal_state_t  state_q, state_d;
  run_state_t  run_q, run_d;
  alerts_t     alert_q, alert_d;
  logic [9:0]  timer_q, timer_d;
  logic [11:0] sub_q, sub_d;
  logic [1:0]  cntr_q, cntr_d;
  logic [9:0]  exp_q, exp_d;
  logic [21:0] ext_q, ext_d;
  logic        hold_lat_q, hold_lat_d;
  logic [4:0]  settle_q, settle_d;
  logic        iir_q, iir_d;
  logic [3:0]  slice_q, slice_d;
  logic        phase_q, phase_d;
  logic [15:0] nol_q, nol_d;
  logic        ack_d;
  logic [31:0] rdat_d;
  logic        shdn_d, even_d, odd_d, meas_d, uvc_d, sum_d;

  logic        wr, rd, wr_ctrl, launch, disable_wr, automated, on;
  logic        unit_tick, finish, halt;
  ctrl_t       wctrl;
  unit_t       unit;
  logic [21:0] exp_sec, ext_len;
  logic [9:0]  timer_rd;

  // reset release through two flops; assertion stays asynchronous
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_s2_q <= rst_s1_q;
    end
  end
  assign rst_n = rst_s2_q;

  // pins from the analog side are not on this clock
  cb_sync3 #(
    .W (4)
  ) u_sync (
    .clk   (CLK),
    .rst_n (rst_n),
    .d     ({TEMP_ALERT, UV_REACHED, CAL_FAULT, MEAS_TIMEOUT}),
    .q     (pins_s)
  );
  assign {temp_s, uv_s, cal_s, tmo_s} = pins_s;

  // one second base, realigned on each launch
  cb_tick #(
    .DIV (SEC_CYC)
  ) u_sec (
    .clk   (CLK),
    .rst_n (rst_n),
    .clr   (launch),
    .tick  (sec_tick)
  );

  // one sixteenth of the even/odd period
  cb_tick #(
    .DIV (SLICE_CYC)
  ) u_slice (
    .clk   (CLK),
    .rst_n (rst_n),
    .clr   (1'b0),
    .tick  (slice_tick)
  );

  // bus decode: one access per ack, ack drops the cycle after
  assign wr      = WB_CYC_I && WB_STB_I && WB_WE_I && !WB_ACK_O;
  assign rd      = WB_CYC_I && WB_STB_I && !WB_WE_I && !WB_ACK_O;
  assign wr_ctrl = wr && (WB_ADR_I == `CB_ADDR_CONTROL);

  // byte lanes merge into the control fields; state bits are read-only
  always_comb begin
    wctrl = ctrl_q;
    if (WB_SEL_I[0]) begin
      wctrl[7:0] = WB_DAT_I[7:0];
    end
    if (WB_SEL_I[1]) begin
      wctrl[`CB_CTRL_MSB:8] = WB_DAT_I[`CB_CTRL_MSB:8];
    end
  end

  assign launch = wr_ctrl && WB_SEL_I[1] &&
                  (wctrl.mode != `CB_MODE_DISABLED);
  assign disable_wr = wr_ctrl && WB_SEL_I[1] &&
                      (wctrl.mode == `CB_MODE_DISABLED);

  // mode decode: discharge and 1xx are the automated ones
  always_comb begin
    automated = (ctrl_q.mode == `CB_MODE_DISCHARGE) || ctrl_q.mode[2];
    if (ctrl_q.mode == `CB_MODE_DISABLED) begin
      unit = UNIT_NONE;
    end else if (ctrl_q.mode == `CB_MODE_DISCHARGE) begin
      unit = UNIT_HOUR;
    end else if (ctrl_q.mode[0] == 1'b0) begin
      unit = UNIT_SEC;
    end else begin
      unit = UNIT_MIN;
    end
  end

  // unit tick and expiry expressed in seconds
  always_comb begin
    unit_tick = 1'b0;
    exp_sec   = 22'(exp_q);
    if (sec_tick) begin
      if (unit == UNIT_SEC) begin
        unit_tick = 1'b1;
      end else if (unit == UNIT_MIN) begin
        unit_tick = (sub_q == 12'(`CB_SEC_PER_MIN - 1));
      end else if (unit == UNIT_HOUR) begin
        unit_tick = (sub_q == 12'(`CB_SEC_PER_HOUR - 1));
      end
    end
    if (unit == UNIT_MIN) begin
      exp_sec = 22'(exp_q) * 22'(`CB_SEC_PER_MIN);
    end else if (unit == UNIT_HOUR) begin
      exp_sec = 22'(exp_q) * 22'(`CB_SEC_PER_HOUR);
    end
  end

  // extension is the greater of five minutes and expiry/16
  assign ext_len = ((exp_sec >> 4) > 22'(`CB_HOLD_MIN_SEC)) ?
                   (exp_sec >> 4) : 22'(`CB_HOLD_MIN_SEC);

  // thermal halt only when enabled; timeout and cal always halt
  assign halt = (ctrl_q.temp_en && temp_s) || tmo_s || cal_s;
  // normal end on expiry or on threshold in automated modes
  assign finish = (unit_tick && (exp_q != `CB_EXP_INFINITE) &&
                   (timer_q + 10'd1 == exp_q)) ||
                  (automated && UV_CHECK_EN && uv_s);

  // control, run sequence, timers and sticky alerts
  always_comb begin
    ctrl_d     = ctrl_q;
    state_d    = state_q;
    run_d      = run_q;
    alert_d    = alert_q;
    timer_d    = timer_q;
    sub_d      = sub_q;
    cntr_d     = cntr_q;
    exp_d      = exp_q;
    ext_d      = ext_q;
    hold_lat_d = hold_lat_q;
    settle_d   = settle_q;
    iir_d      = iir_q;
    if (wr_ctrl) begin
      ctrl_d = wctrl;
    end
    if (wr && (WB_ADR_I == `CB_ADDR_EXPIRY)) begin
      if (WB_SEL_I[0]) begin
        exp_d[7:0] = WB_DAT_I[7:0];
      end
      if (WB_SEL_I[1]) begin
        exp_d[9:8] = WB_DAT_I[9:8];
      end
    end
    // the 1 Hz counter runs in any non-disabled mode
    if (sec_tick && (unit != UNIT_NONE)) begin
      cntr_d = cntr_q + 2'd1;
    end
    // extension counts down in seconds after the operation ends
    if (sec_tick && (ext_q != 22'd0)) begin
      ext_d = ext_q - 22'd1;
    end
    // hold stays latched only while software leaves it at 11
    if (ctrl_q.hold != 2'b11) begin
      hold_lat_d = 1'b0;
    end
    // each finished scan counts down the settle window
    if (SCAN_DONE && (run_q == RUN_BUSY)) begin
      iir_d = 1'b0;
      if (settle_q != 5'd0) begin
        settle_d = settle_q - 5'd1;
      end
    end
    case (run_q)
      RUN_BUSY: begin
        if (sec_tick) begin
          sub_d = unit_tick ? 12'd0 : sub_q + 12'd1;
        end
        if (unit_tick) begin
          timer_d = timer_q + 10'd1;
        end
        if (halt) begin
          run_d   = RUN_END;
          state_d = BAL_HALTED;
          alert_d.thermal = alert_q.thermal | (ctrl_q.temp_en & temp_s);
          alert_d.timeout = alert_q.timeout | tmo_s;
          alert_d.cal     = alert_q.cal | cal_s;
        end else if (finish) begin
          run_d        = RUN_END;
          state_d      = BAL_DONE;
          alert_d.done = 1'b1;
        end
        // extension starts as the operation ends
        if ((halt || finish) && automated &&
            (ctrl_q.hold == 2'b10)) begin
          ext_d = ext_len;
        end
      end
      RUN_END: begin
        run_d = RUN_END;
      end
      default: begin
        run_d = RUN_IDLE;
      end
    endcase
    // status is cleared only by a launch or a disable
    if (launch) begin
      timer_d    = 10'd0;
      sub_d      = 12'd0;
      cntr_d     = 2'd0;
      ext_d      = 22'd0;
      alert_d    = '0;
      run_d      = RUN_BUSY;
      state_d    = BAL_ACTIVE;
      hold_lat_d = (wctrl.mode == `CB_MODE_DISCHARGE) || wctrl.mode[2];
      // filter init and settle window on request
      iir_d      = wctrl.iir_init && wctrl.meas_en[1];
      settle_d   = wctrl.iir_init ? `CB_IIR_SETTLE : 5'd0;
    end else if (disable_wr) begin
      timer_d    = 10'd0;
      sub_d      = 12'd0;
      cntr_d     = 2'd0;
      ext_d      = 22'd0;
      alert_d    = '0;
      run_d      = RUN_IDLE;
      state_d    = BAL_DISABLED;
      hold_lat_d = 1'b0;
      iir_d      = 1'b0;
      settle_d   = 5'd0;
    end
  end

  // pwm slices; nonoverlap blanks the start of every period
  always_comb begin
    slice_d = slice_q;
    phase_d = phase_q;
    nol_d   = (nol_q < 16'(NOL_CYC)) ? nol_q + 16'd1 : nol_q;
    if (slice_tick) begin
      slice_d = slice_q + 4'd1;
      if (slice_q == 4'hf) begin
        phase_d = ~phase_q;
        nol_d   = 16'd0;
      end
    end
  end

  // active while slice index is within duty
  assign on = (slice_q <= ctrl_q.duty) && (nol_q >= 16'(NOL_CYC));

  // output terms, all registered below
  always_comb begin
    even_d = (run_q == RUN_BUSY) && !phase_q && on;
    odd_d  = (run_q == RUN_BUSY) && phase_q && on;
    meas_d = (run_q == RUN_BUSY) && ctrl_q.meas_en[1];
    // checks held off during the settle window
    uvc_d  = (run_q == RUN_BUSY) && (ctrl_q.meas_en == 2'b11) &&
             (settle_q == 5'd0);
    shdn_d = ((run_q == RUN_BUSY) && automated &&
              (ctrl_q.hold != 2'b00)) ||
             (ext_q != 22'd0) ||
             (hold_lat_q && (ctrl_q.hold == 2'b11));
    // done enters the summary only when enabled
    sum_d  = alert_q.thermal || alert_q.timeout || alert_q.cal ||
             (alert_q.done && ctrl_q.done_en);
  end

  // timer reads back the expiry while an extension runs
  assign timer_rd = (ext_q != 22'd0) ? exp_q : timer_q;

  // read mux; unmapped addresses answer zero with ack
  always_comb begin
    ack_d  = WB_CYC_I && WB_STB_I && !WB_ACK_O;
    rdat_d = WB_DAT_O;
    if (rd) begin
      if (WB_ADR_I == `CB_ADDR_CONTROL) begin
        // state field above the control fields
        rdat_d = {16'h0000, state_q, ctrl_q};
      end else if (WB_ADR_I == `CB_ADDR_STATUS) begin
        rdat_d = {16'h0000, state_q, unit, cntr_q, timer_rd};
      end else if (WB_ADR_I == `CB_ADDR_EXPIRY) begin
        rdat_d = {22'h000000, exp_q};
      end else if (WB_ADR_I == `CB_ADDR_ALERTS) begin
        rdat_d = {28'h0000000, alert_q};
      end else begin
        rdat_d = 32'h00000000;
      end
    end
  end

  // everything resets to zero except the expiry setting and the run state (RUN_IDLE)
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q         <= `CB_CTRL_RESET;
      state_q        <= BAL_DISABLED;
      run_q          <= RUN_IDLE;
      alert_q        <= '0;
      timer_q        <= 10'd0;
      sub_q          <= 12'd0;
      cntr_q         <= 2'd0;
      exp_q          <= `CB_EXP_RESET;
      ext_q          <= 22'd0;
      hold_lat_q     <= 1'b0;
      settle_q       <= 5'd0;
      iir_q          <= 1'b0;
      slice_q        <= 4'd0;
      phase_q        <= 1'b0;
      nol_q          <= 16'd0;
      WB_ACK_O       <= 1'b0;
      WB_DAT_O       <= 32'h00000000;
      SHUTDOWN_PIN   <= 1'b0;
      EVEN_SWITCH_EN <= 1'b0;
      ODD_SWITCH_EN  <= 1'b0;
      MEAS_ENABLE    <= 1'b0;
      UV_CHECK_EN    <= 1'b0;
      FILTER_INIT    <= 1'b0;
      SUMMARY_ALERT  <= 1'b0;
    end else begin
      ctrl_q         <= ctrl_d;
      state_q        <= state_d;
      run_q          <= run_d;
      alert_q        <= alert_d;
      timer_q        <= timer_d;
      sub_q          <= sub_d;
      cntr_q         <= cntr_d;
      exp_q          <= exp_d;
      ext_q          <= ext_d;
      hold_lat_q     <= hold_lat_d;
      settle_q       <= settle_d;
      iir_q          <= iir_d;
      slice_q        <= slice_d;
      phase_q        <= phase_d;
      nol_q          <= nol_d;
      WB_ACK_O       <= ack_d;
      WB_DAT_O       <= rdat_d;
      SHUTDOWN_PIN   <= shdn_d;
      EVEN_SWITCH_EN <= even_d;
      ODD_SWITCH_EN  <= odd_d;
      MEAS_ENABLE    <= meas_d;
      UV_CHECK_EN    <= uvc_d;
      FILTER_INIT    <= iir_d;
      SUMMARY_ALERT  <= sum_d;
    end
  end
endmodule

// ---- cell_balance_control_chk.sv ----
// assertion checker for the cell balancing control block
`timescale 1ns/1ps
`include "cb_consts.svh"
module cell_balance_control_chk (
  input wire logic        CLK,            // system clock
  input wire logic        ARST_N,         // reset, low
  input wire logic        WB_CYC_I,       // bus cycle
  input wire logic        WB_STB_I,       // bus strobe
  input wire logic        WB_WE_I,        // bus write
  input wire logic [9:0]  WB_ADR_I,       // bus address
  input wire logic [3:0]  WB_SEL_I,       // byte selects
  input wire logic [31:0] WB_DAT_I,       // write data
  input wire logic        WB_ACK_O,       // acknowledge
  input wire logic        SHUTDOWN_PIN,   // hold output
  input wire logic        EVEN_SWITCH_EN, // even switches
  input wire logic        ODD_SWITCH_EN,  // odd switches
  input wire logic        MEAS_ENABLE,    // measurements on
  input wire logic        UV_CHECK_EN,    // threshold checks
  input wire logic        FILTER_INIT,    // filter init
  input wire logic        SUMMARY_ALERT   // summary alert
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!ARST_N);

  // a request the slave has not answered yet
  sequence req_taken;
    WB_CYC_I && WB_STB_I && !WB_ACK_O;
  endsequence
  // a control write that selects the disabled mode
  sequence wr_off;
    req_taken and (WB_WE_I && WB_SEL_I[1] &&
    WB_ADR_I == `CB_ADDR_CONTROL && WB_DAT_I[13:11] == 3'b000);
  endsequence

  ack_next_a: assert property (req_taken |=> WB_ACK_O)
    else $error("request not acknowledged next cycle");
  ack_pulse_a: assert property (WB_ACK_O |=> !WB_ACK_O)
    else $error("acknowledge longer than one cycle");
  switch_excl_a: assert property (!(EVEN_SWITCH_EN && ODD_SWITCH_EN))
    else $error("even and odd switches on together");
  even_gap_a: assert property ($fell(EVEN_SWITCH_EN) |=> !ODD_SWITCH_EN [*8])
    else $error("odd switches on without gap");
  odd_gap_a: assert property ($fell(ODD_SWITCH_EN) |=> !EVEN_SWITCH_EN [*8])
    else $error("even switches on without gap");
  uv_meas_a: assert property (UV_CHECK_EN |-> MEAS_ENABLE)
    else $error("threshold checks without measurements");
  filter_uv_a: assert property (FILTER_INIT |-> !UV_CHECK_EN)
    else $error("threshold checks during filter init");
  disable_off_a: assert property (wr_off |-> ##3 !EVEN_SWITCH_EN && !ODD_SWITCH_EN)
    else $error("switches still on after disable");
  reset_quiet_a: assert property ($rose(ARST_N) |-> !WB_ACK_O &&
    !SHUTDOWN_PIN && !SUMMARY_ALERT && !MEAS_ENABLE)
    else $error("outputs active at reset release");
endmodule

bind cell_balance_control cell_balance_control_chk u_chk (.CLK, .ARST_N,
  .WB_CYC_I, .WB_STB_I, .WB_WE_I, .WB_ADR_I, .WB_SEL_I, .WB_DAT_I,
  .WB_ACK_O, .SHUTDOWN_PIN, .EVEN_SWITCH_EN, .ODD_SWITCH_EN, .MEAS_ENABLE,
  .UV_CHECK_EN, .FILTER_INIT, .SUMMARY_ALERT);

// ---- tb_cell_balance_control.sv ----
// self-checking bench for the cell balancing control block
`timescale 1ns/1ps
`include "cb_consts.svh"
module tb_cell_balance_control;
  logic        CLK, ARST_N, WB_CYC_I, WB_STB_I, WB_WE_I, WB_ACK_O;
  logic [9:0]  WB_ADR_I;
  logic [3:0]  WB_SEL_I;
  logic [31:0] WB_DAT_I, WB_DAT_O;
  logic        TEMP_ALERT, UV_REACHED, CAL_FAULT, MEAS_TIMEOUT, SCAN_DONE;
  logic        SHUTDOWN_PIN, EVEN_SWITCH_EN, ODD_SWITCH_EN, MEAS_ENABLE;
  logic        UV_CHECK_EN, FILTER_INIT, SUMMARY_ALERT;
  logic [15:0] rd;
  int          fails, checked;

  // short second and period keep the run small
  cell_balance_control #(.SEC_CYC(20), .EOP_CYC(320)) dut (.CLK, .ARST_N,
    .WB_CYC_I, .WB_STB_I, .WB_WE_I, .WB_ADR_I, .WB_SEL_I, .WB_DAT_I,
    .WB_DAT_O, .WB_ACK_O, .TEMP_ALERT, .UV_REACHED, .CAL_FAULT,
    .MEAS_TIMEOUT, .SCAN_DONE, .SHUTDOWN_PIN, .EVEN_SWITCH_EN,
    .ODD_SWITCH_EN, .MEAS_ENABLE, .UV_CHECK_EN, .FILTER_INIT, .SUMMARY_ALERT);

  always #5 CLK = ~CLK;

  // one classic bus cycle, held until ack is sampled; the watchdog ends a hang
  task automatic bus(input logic w, input logic [9:0] a,
                     input logic [15:0] d);
    @(posedge CLK);
    WB_CYC_I <= 1'b1;
    WB_STB_I <= 1'b1;
    WB_WE_I <= w;
    WB_ADR_I <= a;
    WB_SEL_I <= 4'h3;
    WB_DAT_I <= {16'h0000, d};
    do begin
      @(posedge CLK);
    end while (WB_ACK_O !== 1'b1);
    rd = WB_DAT_O[15:0];
    WB_CYC_I <= 1'b0;
    WB_STB_I <= 1'b0;
    WB_SEL_I <= 4'h0;
  endtask

  task automatic chk(input string nm, input logic [15:0] e, g);
    checked++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic pin(input string nm, input logic e, g);
    checked++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %s expected %b seen %b", nm, e, g);
    end
  endtask

  task automatic rchk(input string nm, input logic [9:0] a,
                      input logic [15:0] e);
    bus(1'b0, a, 16'h0000);
    chk(nm, e, rd);
  endtask

  // poll the state field; synchronisers make the latency loose
  task automatic wait_st(input logic [1:0] s);
    int n;
    n = 0;
    do begin
      bus(1'b0, `CB_ADDR_STATUS, 16'h0000);
      n++;
    end while (rd[15:14] !== s && n < 100);
    chk("state", {14'h0, s}, {14'h0, rd[15:14]});
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge CLK);
  endtask

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // watchdog, about two and a half times the eight thousand cycles the tests need
  initial begin
    #200000;
    fails++;
    report_and_stop();
  end

  initial begin
    {CLK, ARST_N, WB_CYC_I, WB_STB_I, WB_WE_I, SCAN_DONE} = 6'h00;
    {TEMP_ALERT, UV_REACHED, CAL_FAULT, MEAS_TIMEOUT} = 4'h0;
    WB_ADR_I = 10'h000;
    WB_SEL_I = 4'h0;
    WB_DAT_I = 32'h0000_0000;
    fails = 0;
    checked = 0;
    settle(3);
    ARST_N <= 1'b1;
    settle(3);
    rchk("control", `CB_ADDR_CONTROL, 16'h0000);
    rchk("status", `CB_ADDR_STATUS, 16'h0000);
    rchk("unmapped", 10'h3fc, 16'h0000);
    bus(1'b1, `CB_ADDR_CONTROL, 16'hc000);
    rchk("control", `CB_ADDR_CONTROL, 16'h0000);
    $display("test reset done");
    for (int m = 1; m < 8; m++) begin
      bus(1'b1, `CB_ADDR_CONTROL, {2'b00, m[2:0], 11'h000});
      rchk("control", `CB_ADDR_CONTROL, {2'b01, m[2:0], 11'h000});
      rchk("status", `CB_ADDR_STATUS, {2'b01, (m == 1) ? 2'b11 :
           (m[0] ? 2'b10 : 2'b01), 12'h000});
    end
    bus(1'b1, `CB_ADDR_CONTROL, 16'h0000);
    rchk("status", `CB_ADDR_STATUS, 16'h0000);
    $display("test modes done");
    bus(1'b1, `CB_ADDR_EXPIRY, 16'h0003);
    bus(1'b1, `CB_ADDR_CONTROL, 16'h1008);
    wait_st(2'b10);
    rchk("alerts", `CB_ADDR_ALERTS, 16'h0001);
    pin("summary", 1'b1, SUMMARY_ALERT);
    bus(1'b1, `CB_ADDR_CONTROL, 16'h1000);
    rchk("alerts", `CB_ADDR_ALERTS, 16'h0000);
    wait_st(2'b10);
    pin("summary", 1'b0, SUMMARY_ALERT);
    // hold 10 on a 3 s automated run: extension is the 300 s floor
    bus(1'b1, `CB_ADDR_CONTROL, 16'h2200);
    wait_st(2'b10);
    pin("shdn", 1'b1, SHUTDOWN_PIN);
    settle(5900);
    pin("shdn", 1'b1, SHUTDOWN_PIN);
    settle(200);
    pin("shdn", 1'b0, SHUTDOWN_PIN);
    bus(1'b1, `CB_ADDR_EXPIRY, 16'h03ff);
    $display("test expiry done");
    bus(1'b1, `CB_ADDR_CONTROL, 16'h2000);
    TEMP_ALERT <= 1'b1;
    settle(12);
    wait_st(2'b01);
    TEMP_ALERT <= 1'b0;
    settle(8);
    for (int i = 0; i < 3; i++) begin
      bus(1'b1, `CB_ADDR_CONTROL, 16'h2004);
      {CAL_FAULT, MEAS_TIMEOUT, TEMP_ALERT} <= 3'b001 << i;
      wait_st(2'b11);
      rchk("alerts", `CB_ADDR_ALERTS, 16'h0002 << i);
      pin("summary", 1'b1, SUMMARY_ALERT);
      {CAL_FAULT, MEAS_TIMEOUT, TEMP_ALERT} <= 3'b000;
      settle(8);
    end
    $display("test halts done");
    bus(1'b1, `CB_ADDR_CONTROL, 16'h2002);
    settle(4);
    pin("meas", 1'b1, MEAS_ENABLE);
    pin("uvchk", 1'b0, UV_CHECK_EN);
    bus(1'b1, `CB_ADDR_CONTROL, 16'h2000);
    settle(4);
    pin("meas", 1'b0, MEAS_ENABLE);
    bus(1'b1, `CB_ADDR_CONTROL, 16'h2403);
    settle(4);
    pin("finit", 1'b1, FILTER_INIT);
    for (int i = 0; i < 16; i++) begin
      pin("uvchk", 1'b0, UV_CHECK_EN);
      SCAN_DONE <= 1'b1;
      @(posedge CLK);
      SCAN_DONE <= 1'b0;
      settle(2);
    end
    pin("finit", 1'b0, FILTER_INIT);
    pin("uvchk", 1'b1, UV_CHECK_EN);
    UV_REACHED <= 1'b1;
    wait_st(2'b10);
    UV_REACHED <= 1'b0;
    settle(8);
    $display("test measure done");
    bus(1'b1, `CB_ADDR_CONTROL, 16'h1100);
    settle(4);
    pin("shdn", 1'b0, SHUTDOWN_PIN);
    bus(1'b1, `CB_ADDR_CONTROL, 16'h0970);
    settle(700);
    pin("shdn", 1'b1, SHUTDOWN_PIN);
    CAL_FAULT <= 1'b1;
    wait_st(2'b11);
    settle(2);
    pin("shdn", 1'b0, SHUTDOWN_PIN);
    CAL_FAULT <= 1'b0;
    settle(8);
    bus(1'b1, `CB_ADDR_CONTROL, 16'h0bf0);
    settle(700);
    CAL_FAULT <= 1'b1;
    wait_st(2'b11);
    settle(2);
    pin("shdn", 1'b1, SHUTDOWN_PIN);
    CAL_FAULT <= 1'b0;
    bus(1'b1, `CB_ADDR_CONTROL, 16'h0000);
    settle(4);
    pin("shdn", 1'b0, SHUTDOWN_PIN);
    pin("even", 1'b0, EVEN_SWITCH_EN);
    pin("odd", 1'b0, ODD_SWITCH_EN);
    rchk("status", `CB_ADDR_STATUS, 16'h0000);
    $display("test hold done");
    report_and_stop();
  end
endmodule
